// ---- cc_vbus_threshold_match_status.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cc_vbus_defines.svh"

module cc_vbus_threshold_match_status #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// register port
	input  wire cc_vbus_pkg::reg_req_s    reg_req,
	output var  cc_vbus_pkg::reg_rsp_s    reg_rsp,
	// comparator outputs, asynchronous
	input  wire logic [7:0]               cc1_raw,
	input  wire logic [7:0]               cc2_raw,
	input  wire logic [3:0]               vbus_level_raw,
	input  wire logic                     vbus_near_zero_raw,
	// control from the line control logic
	input  wire cc_vbus_pkg::conn_state_e conn_state,
	input  wire logic                     role_dfp,
	input  wire logic                     standalone,
	input  wire logic                     cc_comparator_enable,
	input  wire logic                     vbus_comparator_enable,
	input  wire logic [7:0]               cc1_debounce_clear_enable,
	input  wire logic [7:0]               cc2_debounce_clear_enable,
	input  wire logic [7:0]               vbus_debounce_clear_enable,
	input  wire logic [CNT_W-1:0]         unattached_debounce_time,
	input  wire logic [CNT_W-1:0]         attached_debounce_time,
	input  wire logic                     cc_first_match_clear,
	input  wire logic                     vbus_first_match_clear,
	// status out
	output logic      [1:0]               line_interrupt_flags,
	output logic                          cc_first_match_valid,
	output logic                          vbus_first_match_valid
);

	import cc_vbus_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		hit_vec_s    sync1;
		hit_vec_s    sync2;
		hit_vec_s    hits;
		hit_vec_s    flags;
		conn_state_e prev_conn;
		logic        cc_seen;
		logic        vbus_seen;
		logic        cc_valid;
		logic        vbus_valid;
		logic [1:0]  line_irq;
		reg_rsp_s    rsp;
	} top_state_s;

	top_state_s s;
	top_state_s next_s;

	logic [7:0]       cc_default;
	logic [7:0]       vbus_mapped;
	logic [CNT_W-1:0] cc_time;
	logic             restart;
	logic [7:0]       cc1_deb;
	logic [7:0]       cc2_deb;
	logic [7:0]       vbus_deb;
	logic             cc1_settle;
	logic             cc2_settle;
	logic             vbus_settle;
	logic             cc_open;
	logic             vbus_open;
	logic [7:0]       clr_cc1;
	logic [7:0]       clr_cc2;
	logic [7:0]       clr_vbus;

	// ****************************************
	// input mapping and debounce timing
	// ****************************************
	// role picks reset image
	assign cc_default = role_dfp ? `CC_HITS_DFP_RESET : `CC_HITS_UFP_RESET;

	// level bits placed at 5:2, near zero at 0
	always_comb begin
		vbus_mapped = `VBUS_HITS_RESET;
		vbus_mapped[`VBUS_LEVEL3_BIT:`VBUS_LEVEL0_BIT] = vbus_level_raw;
		vbus_mapped[`VBUS_NEAR_ZERO_BIT] = vbus_near_zero_raw;
	end

	// attach wait and attached share the attached window
	always_comb begin
		unique case (conn_state)
			unattached:      cc_time = unattached_debounce_time;
			attach_wait:     cc_time = attached_debounce_time;
			attached_source: cc_time = attached_debounce_time;
			attached_sink:   cc_time = attached_debounce_time;
		endcase
	end

	// a state change restarts every line window
	assign restart = (conn_state != s.prev_conn);

	match_debounce #(
		.WIDTH (8),
		.CNT_W (CNT_W)
	) u_deb_cc1 (
		.clk      (clk),
		.srst     (srst),
		.raw      (s.sync2.cc1),
		.deb_time (cc_time),
		.restart  (restart),
		.stable   (cc1_deb),
		.settle   (cc1_settle)
	);

	match_debounce #(
		.WIDTH (8),
		.CNT_W (CNT_W)
	) u_deb_cc2 (
		.clk      (clk),
		.srst     (srst),
		.raw      (s.sync2.cc2),
		.deb_time (cc_time),
		.restart  (restart),
		.stable   (cc2_deb),
		.settle   (cc2_settle)
	);

	// bus sense has no connection-state windows, so it uses the attached one
	match_debounce #(
		.WIDTH (8),
		.CNT_W (CNT_W)
	) u_deb_vbus (
		.clk      (clk),
		.srst     (srst),
		.raw      (s.sync2.vbus),
		.deb_time (attached_debounce_time),
		.restart  (1'b0),
		.stable   (vbus_deb),
		.settle   (vbus_settle)
	);

	// ****************************************
	// write-one-clear decode
	// ****************************************
	always_comb begin
		clr_cc1 = 8'h00;
		clr_cc2 = 8'h00;
		clr_vbus = 8'h00;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`ADDR_CC1_CHANGE_FLAGS:  clr_cc1 = reg_req.wdata;
				`ADDR_CC2_CHANGE_FLAGS:  clr_cc2 = reg_req.wdata;
				`ADDR_VBUS_CHANGE_FLAGS: clr_vbus = reg_req.wdata;
				default:                 clr_cc1 = 8'h00;
			endcase
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.sync1.cc1 = cc1_raw;
		next_s.sync1.cc2 = cc2_raw;
		next_s.sync1.vbus = vbus_mapped;
		next_s.sync2 = s.sync1;
		next_s.prev_conn = conn_state;
		next_s.cc_seen = s.cc_seen | cc_comparator_enable;
		next_s.vbus_seen = s.vbus_seen | vbus_comparator_enable;
		cc_open = standalone | next_s.cc_seen;
		vbus_open = standalone | next_s.vbus_seen;

		// hold reset image until comparator enabled
		if (!cc_open) begin
			next_s.hits.cc1 = cc_default;
			next_s.hits.cc2 = cc_default;
		end else begin
			next_s.hits.cc1 = (cc1_debounce_clear_enable & cc1_deb)
				| (~cc1_debounce_clear_enable & s.sync2.cc1);
			next_s.hits.cc2 = (cc2_debounce_clear_enable & cc2_deb)
				| (~cc2_debounce_clear_enable & s.sync2.cc2);
		end

		if (!vbus_open) begin
			next_s.hits.vbus = `VBUS_HITS_RESET;
		end else begin
			next_s.hits.vbus = ((vbus_debounce_clear_enable & vbus_deb)
				| (~vbus_debounce_clear_enable & s.sync2.vbus)) & `VBUS_DEFINED_MASK;
		end

		next_s.flags.cc1 = (s.flags.cc1 & ~clr_cc1) | (next_s.hits.cc1 ^ s.hits.cc1);
		next_s.flags.cc2 = (s.flags.cc2 & ~clr_cc2) | (next_s.hits.cc2 ^ s.hits.cc2);
		next_s.flags.vbus = (s.flags.vbus & ~clr_vbus) | (next_s.hits.vbus ^ s.hits.vbus);

		next_s.line_irq = {|next_s.flags.cc2, |next_s.flags.cc1};

		next_s.cc_valid = (s.cc_valid & ~cc_first_match_clear)
			| (s.cc_seen & (cc1_settle | cc2_settle));
		next_s.vbus_valid = (s.vbus_valid & ~vbus_first_match_clear)
			| (s.vbus_seen & vbus_settle);

		// read answers one cycle later; unmapped reads zero
		next_s.rsp.rvalid = reg_req.rd;
		next_s.rsp.rdata = `UNMAPPED_READ;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`ADDR_CC1_CHANGE_FLAGS:   next_s.rsp.rdata = s.flags.cc1;
				`ADDR_CC2_CHANGE_FLAGS:   next_s.rsp.rdata = s.flags.cc2;
				`ADDR_CC1_THRESHOLD_HITS: next_s.rsp.rdata = s.hits.cc1;
				`ADDR_CC2_THRESHOLD_HITS: next_s.rsp.rdata = s.hits.cc2;
				`ADDR_VBUS_THRESHOLD_HITS: next_s.rsp.rdata = s.hits.vbus;
				`ADDR_VBUS_CHANGE_FLAGS:  next_s.rsp.rdata = s.flags.vbus;
				default:                  next_s.rsp.rdata = `UNMAPPED_READ;
			endcase
		end

		if (srst) begin
			next_s = '0;
			next_s.prev_conn = conn_state;
			next_s.hits.cc1 = cc_default;
			next_s.hits.cc2 = cc_default;
			next_s.flags = {`CHANGE_FLAGS_RESET, `CHANGE_FLAGS_RESET, `CHANGE_FLAGS_RESET};
			next_s.hits.vbus = `VBUS_HITS_RESET;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rsp = s.rsp;
	assign line_interrupt_flags = s.line_irq;
	assign cc_first_match_valid = s.cc_valid;
	assign vbus_first_match_valid = s.vbus_valid;

	// ****************************************
	// checks
	// ****************************************
	sequence wipe_cc1_s;
		reg_req.wr && reg_req.addr == `ADDR_CC1_CHANGE_FLAGS && reg_req.wdata == 8'hff;
	endsequence

	sequence quiet_cc1_s;
		s.hits.cc1 == $past(s.hits.cc1);
	endsequence

	wipe_clears_a: assert property (@(posedge clk) disable iff (srst)
		wipe_cc1_s ##1 quiet_cc1_s |-> s.flags.cc1 == 8'h00)
		else $error("write of ones left a line flag set");

	cc_change_flag_a: assert property (@(posedge clk) disable iff (srst)
		((s.hits.cc2 ^ $past(s.hits.cc2)) & ~s.flags.cc2) == 8'h00)
		else $error("line hit changed without setting its flag");

	vbus_change_flag_a: assert property (@(posedge clk) disable iff (srst)
		((s.hits.vbus ^ $past(s.hits.vbus)) & ~s.flags.vbus) == 8'h00)
		else $error("bus hit changed without setting its flag");

	set_beats_clear_a: assert property (@(posedge clk) disable iff (srst)
		(reg_req.wr && reg_req.addr == `ADDR_CC1_CHANGE_FLAGS
			&& ((next_s.hits.cc1 ^ s.hits.cc1) & reg_req.wdata) != 8'h00)
		|=> (s.flags.cc1 & $past(reg_req.wdata) & (s.hits.cc1 ^ $past(s.hits.cc1))) != 8'h00)
		else $error("event lost under a same-cycle clear");

	reset_image_a: assert property (@(posedge clk)
		$past(srst) |-> s.hits.cc1 == ($past(role_dfp) ? 8'hff : 8'h00)
			&& s.flags == '0 && s.hits.vbus == 8'h00)
		else $error("wrong reset image");

	cc_gate_a: assert property (@(posedge clk) disable iff (srst)
		(!standalone && !s.cc_seen && !cc_comparator_enable) |=>
			s.hits.cc2 == ($past(role_dfp) ? 8'hff : 8'h00))
		else $error("line hits moved before comparator enable");

	vbus_gate_a: assert property (@(posedge clk) disable iff (srst)
		(!standalone && !s.vbus_seen && !vbus_comparator_enable) |=> s.hits.vbus == 8'h00)
		else $error("bus hits moved before comparator enable");

	vbus_reserved_a: assert property (@(posedge clk) disable iff (srst)
		s.hits.vbus[7:6] == 2'b00 && s.hits.vbus[1] == 1'b0)
		else $error("reserved bus hit bit set");

	raw_pass_a: assert property (@(posedge clk) disable iff (srst)
		(cc1_debounce_clear_enable == 8'h00 && s.cc_seen) |=>
			s.hits.cc1 == $past(s.sync2.cc1))
		else $error("raw line value not shown with debounce off");

	// placement checked at the synchroniser output, whatever the debounce mode
	vbus_map_a: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) && !$past(srst, 2) |->
			s.sync2.vbus[5:2] == $past(vbus_level_raw, 2)
			&& s.sync2.vbus[0] == $past(vbus_near_zero_raw, 2))
		else $error("bus level bits misplaced");

	irq_tracks_a: assert property (@(posedge clk) disable iff (srst)
		s.line_irq == {|s.flags.cc2, |s.flags.cc1})
		else $error("line interrupt bits disagree with flags");

	cc_valid_cause_a: assert property (@(posedge clk) disable iff (srst)
		$rose(s.cc_valid) |-> $past(s.cc_seen) && $past(cc1_settle || cc2_settle))
		else $error("line first-match-valid without a settled result");

	vbus_valid_cause_a: assert property (@(posedge clk) disable iff (srst)
		$rose(s.vbus_valid) |-> $past(s.vbus_seen) && $past(vbus_settle))
		else $error("bus first-match-valid without a settled result");

	cc1_change_flag_a: assert property (@(posedge clk) disable iff (srst)
		((s.hits.cc1 ^ $past(s.hits.cc1)) & ~s.flags.cc1) == 8'h00)
		else $error("line 1 hit changed without setting its flag");

	cc1_flag_hold_a: assert property (@(posedge clk) disable iff (srst)
		($past(s.flags.cc1) & ~s.flags.cc1 & ~$past(clr_cc1)) == 8'h00)
		else $error("line 1 flag dropped without a write of one");

	cc2_flag_hold_a: assert property (@(posedge clk) disable iff (srst)
		($past(s.flags.cc2) & ~s.flags.cc2 & ~$past(clr_cc2)) == 8'h00)
		else $error("line 2 flag dropped without a write of one");

	vbus_flag_hold_a: assert property (@(posedge clk) disable iff (srst)
		($past(s.flags.vbus) & ~s.flags.vbus & ~$past(clr_vbus)) == 8'h00)
		else $error("bus flag dropped without a write of one");

	cc_valid_sticky_a: assert property (@(posedge clk) disable iff (srst)
		s.cc_valid && !cc_first_match_clear |=> s.cc_valid)
		else $error("line first-match-valid dropped without a clear");

	vbus_valid_sticky_a: assert property (@(posedge clk) disable iff (srst)
		s.vbus_valid && !vbus_first_match_clear |=> s.vbus_valid)
		else $error("bus first-match-valid dropped without a clear");

endmodule

`default_nettype wire

// ---- cc_vbus_defines.svh ----
// Behaviour
// - each line's change flag bit sets when its matching hit bit changes
// - writing one clears a change flag, zero leaves it; flags reset to zero
// - each of eight line hit bits shows its threshold is exceeded
// - when unattached, line hits update after the unattached debounce time
// - while confirming an attach, line hits update after the attached debounce time
// - while attached as source or sink, hits update after the attached debounce time
// - line hits reset to all ones as downstream port, all zeros as upstream
// - debounce-clear enable picks debounced value per bit, else raw comparator value
// - outside standalone, line hits read reset value until comparator enabled
// - bus hits: bits 5 to 2 carry levels 3 to 0, bit 0 near zero
// - bus hit bits 7:6 and 1 reserved; all bus hit bits read-only, reset zero
// - outside standalone, bus hits read zero until bus comparator enabled
// - bus hits debounced according to the bus debounce-clear enable bits
// - bus change flag bit sets when its hit bit changes; resets to zero
// - line interrupt bits 1 and 0 show a change flag is pending per line
// - line first-match-valid sets once enabled and first debounced result lands
// - bus first-match-valid sets once enabled and first debounced result lands
`ifndef CC_VBUS_DEFINES_SVH
`define CC_VBUS_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CC1_CHANGE_FLAGS   16'h0804
`define ADDR_CC2_CHANGE_FLAGS   16'h0805
`define ADDR_CC1_THRESHOLD_HITS 16'h0806
`define ADDR_CC2_THRESHOLD_HITS 16'h0807
`define ADDR_VBUS_THRESHOLD_HITS 16'h0808
`define ADDR_VBUS_CHANGE_FLAGS  16'h0809

// ****************************************
// reset values and fields
// ****************************************
`define CHANGE_FLAGS_RESET      8'h00
`define CC_HITS_DFP_RESET       8'hff
`define CC_HITS_UFP_RESET       8'h00
`define VBUS_HITS_RESET         8'h00
`define VBUS_DEFINED_MASK       8'h3d
`define VBUS_LEVEL0_BIT         2
`define VBUS_LEVEL3_BIT         5
`define VBUS_NEAR_ZERO_BIT      0
`define UNMAPPED_READ           8'h00

`endif

// ---- cc_vbus_pkg.sv ----
package cc_vbus_pkg;

	typedef enum logic [1:0] {
		unattached,
		attach_wait,
		attached_source,
		attached_sink
	} conn_state_e;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} reg_req_s;

	typedef struct packed {
		logic        rvalid;
		logic [7:0]  rdata;
	} reg_rsp_s;

	typedef struct packed {
		logic [7:0] cc1;
		logic [7:0] cc2;
		logic [7:0] vbus;
	} hit_vec_s;

endpackage

// ---- match_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none

module match_debounce #(
	parameter int WIDTH = 8,
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// sample and timing
	input  wire logic [WIDTH-1:0] raw,
	input  wire logic [CNT_W-1:0] deb_time,
	input  wire logic             restart,
	// result
	output logic      [WIDTH-1:0] stable,
	output logic                  settle
);

	typedef struct packed {
		logic [WIDTH-1:0] last;
		logic [WIDTH-1:0] stable;
		logic [CNT_W-1:0] count;
		logic             settle;
	} deb_state_s;

	deb_state_s s;
	deb_state_s next_s;

	always_comb begin
		next_s = s;
		next_s.settle = 1'b0;
		// any movement restarts the stability window
		if (raw != s.last || restart) begin
			next_s.last = raw;
			next_s.count = '0;
		end else if (s.count < deb_time) begin
			next_s.count = s.count + 1'b1;
		end else if (s.stable != s.last) begin
			next_s.stable = s.last;
			next_s.settle = 1'b1;
		end
		if (srst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	assign stable = s.stable;
	assign settle = s.settle;

	settle_after_window_a: assert property (@(posedge clk) disable iff (srst)
		s.settle |-> $past(s.count) == $past(deb_time))
		else $error("debounced value moved before its window elapsed");

endmodule

`default_nettype wire

// ---- line_comparator_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****
// analogue comparator bank
// ****
module line_comparator_model #(
	parameter int CC_STEP   = 200,
	parameter int VBUS_STEP = 1000,
	parameter int NEAR_ZERO = 600
) (
	// sensed levels, millivolts
	input  wire logic [15:0] cc1_mv,
	input  wire logic [15:0] cc2_mv,
	input  wire logic [15:0] vbus_mv,
	// comparator outputs
	output logic      [7:0]  cc1_raw,
	output logic      [7:0]  cc2_raw,
	output logic      [3:0]  vbus_level_raw,
	output logic             vbus_near_zero_raw
);
	// ideal, no hysteresis: tests never sit on a level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			cc1_raw[i] = cc1_mv > CC_STEP * (i + 1);
			cc2_raw[i] = cc2_mv > CC_STEP * (i + 1);
		end
		for (int i = 0; i < 4; i++) begin
			vbus_level_raw[i] = vbus_mv > VBUS_STEP * (i + 1);
		end
		vbus_near_zero_raw = vbus_mv > NEAR_ZERO;
	end
endmodule

`default_nettype wire

// ---- cc_vbus_threshold_match_status_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module cc_vbus_threshold_match_status_bench;
	import cc_vbus_pkg::*;

	logic        clk;
	logic        srst;
	reg_req_s    req;
	reg_rsp_s    rsp;
	logic [7:0]  cc1_raw;
	logic [7:0]  cc2_raw;
	logic [3:0]  lvl_raw;
	logic        nz_raw;
	logic [15:0] cc1_mv;
	logic [15:0] cc2_mv;
	logic [15:0] vbus_mv;
	conn_state_e conn;
	logic        role_dfp;
	logic        alone;
	logic        cc_en;
	logic        vb_en;
	logic [7:0]  cc1_dc;
	logic [7:0]  cc2_dc;
	logic [7:0]  vb_dc;
	logic [1:0]  irq;
	logic        cc_fv;
	logic        vb_fv;
	int          err_total;
	int          cmp_count;
	int          cycles;

	line_comparator_model cmp (
		.cc1_mv             (cc1_mv),
		.cc2_mv             (cc2_mv),
		.vbus_mv            (vbus_mv),
		.cc1_raw            (cc1_raw),
		.cc2_raw            (cc2_raw),
		.vbus_level_raw     (lvl_raw),
		.vbus_near_zero_raw (nz_raw)
	);

	cc_vbus_threshold_match_status dut (
		.clk                        (clk),
		.srst                       (srst),
		.reg_req                    (req),
		.reg_rsp                    (rsp),
		.cc1_raw                    (cc1_raw),
		.cc2_raw                    (cc2_raw),
		.vbus_level_raw             (lvl_raw),
		.vbus_near_zero_raw         (nz_raw),
		.conn_state                 (conn),
		.role_dfp                   (role_dfp),
		.standalone                 (alone),
		.cc_comparator_enable       (cc_en),
		.vbus_comparator_enable     (vb_en),
		.cc1_debounce_clear_enable  (cc1_dc),
		.cc2_debounce_clear_enable  (cc2_dc),
		.vbus_debounce_clear_enable (vb_dc),
		.unattached_debounce_time   (16'h001e),
		.attached_debounce_time     (16'h0008),
		.cc_first_match_clear       (1'b0),
		.vbus_first_match_clear     (1'b0),
		.line_interrupt_flags       (irq),
		.cc_first_match_valid       (cc_fv),
		.vbus_first_match_valid     (vb_fv)
	);

	// ****
	// clock, timeout, helpers
	// ****
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			summarize();
		end
	end

	task automatic summarize();
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk) begin
			req.rd   <= 1'b1;
			req.addr <= a;
		end
		@(posedge clk) req.rd <= 1'b0;
		#1 chk("rvalid", 8'h01, {7'h00, rsp.rvalid});
		chk($sformatf("reg %h", a), e, rsp.rdata);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) begin
			req.wr    <= 1'b1;
			req.addr  <= a;
			req.wdata <= d;
		end
		@(posedge clk) req.wr <= 1'b0;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		rchk(16'h0806, 8'hff);
		rchk(16'h0807, 8'hff);
		rchk(16'h0808, 8'h00);
		rchk(16'h0804, 8'h00);
		rchk(16'h0805, 8'h00);
		rchk(16'h0809, 8'h00);
		rchk(16'h080a, 8'h00);
		chk("cc valid", 8'h00, {7'h00, cc_fv});
		@(posedge clk) role_dfp <= 1'b0;
		rchk(16'h0806, 8'h00);
		rchk(16'h0804, 8'hff);
		rchk(16'h0805, 8'hff);
		wr(16'h0804, 8'hff);
		wr(16'h0805, 8'hff);
	endtask

	// 650 mV passes levels 0..2, 1700 mV all eight
	task automatic t_raw();
		@(posedge clk) begin
			cc_en  <= 1'b1;
			cc1_mv <= 16'd650;
			cc2_mv <= 16'd1700;
		end
		cyc(6);
		rchk(16'h0806, 8'h07);
		rchk(16'h0807, 8'hff);
		rchk(16'h0804, 8'h07);
		chk("irq", 8'h03, {6'h00, irq});
		wr(16'h0804, 8'h00);
		rchk(16'h0804, 8'h07);
		wr(16'h0804, 8'h05);
		rchk(16'h0804, 8'h02);
		wr(16'h0804, 8'hff);
		wr(16'h0805, 8'hff);
		cyc(1);
		#1;
		chk("irq", 8'h00, {6'h00, irq});
	endtask

	// write-one clear lands on the edge where hits move 07 -> 01
	task automatic t_collide();
		@(posedge clk) cc1_mv <= 16'd250;
		cyc(1);
		@(posedge clk) begin
			req.wr    <= 1'b1;
			req.addr  <= 16'h0804;
			req.wdata <= 8'hff;
		end
		@(posedge clk) req.wr <= 1'b0;
		rchk(16'h0804, 8'h06);
	endtask

	// 2500 mV: levels 0,1 and near zero -> bits 3,2,0
	task automatic t_vbus();
		@(posedge clk) begin
			vb_dc   <= 8'hff;
			vbus_mv <= 16'd2500;
		end
		cyc(12);
		rchk(16'h0808, 8'h00);
		@(posedge clk) vb_en <= 1'b1;
		cyc(15);
		rchk(16'h0808, 8'h0d);
		rchk(16'h0809, 8'h0d);
		wr(16'h0808, 8'hff);
		wr(16'h0809, 8'hff);
		rchk(16'h0808, 8'h0d);
		@(posedge clk) vbus_mv <= 16'd3500;
		cyc(4);
		rchk(16'h0808, 8'h0d);
		cyc(12);
		rchk(16'h0808, 8'h1d);
		rchk(16'h0809, 8'h10);
		chk("vbus valid", 8'h01, {7'h00, vb_fv});
	endtask

	// unattached window is 30 cycles, attached ones 8
	task automatic deb_step(input conn_state_e s, input logic [15:0] mv,
			input logic [7:0] o, input logic [7:0] n, input bit slow);
		@(posedge clk) conn <= s;
		cyc(4);
		@(posedge clk) cc2_mv <= mv;
		cyc(4);
		rchk(16'h0807, o);
		cyc(12);
		rchk(16'h0807, slow ? o : n);
		cyc(30);
		rchk(16'h0807, n);
	endtask

	task automatic t_line_debounce();
		@(posedge clk) cc2_dc <= 8'hff;
		deb_step(unattached, 16'd450, 8'hff, 8'h03, 1'b1);
		deb_step(attach_wait, 16'd1700, 8'h03, 8'hff, 1'b0);
		deb_step(attached_sink, 16'd450, 8'hff, 8'h03, 1'b0);
		deb_step(attached_source, 16'd1700, 8'h03, 8'hff, 1'b0);
		chk("cc valid", 8'h01, {7'h00, cc_fv});
	endtask

	// mid-run reset into standalone: hits follow the comparators with enables off
	task automatic t_alone();
		@(posedge clk) begin
			srst  <= 1'b1;
			alone <= 1'b1;
			cc_en <= 1'b0;
			vb_en <= 1'b0;
			vb_dc <= 8'h00;
		end
		cyc(2);
		@(posedge clk) srst <= 1'b0;
		cyc(4);
		rchk(16'h0806, 8'h01);
		rchk(16'h0808, 8'h1d);
		chk("cc valid", 8'h00, {7'h00, cc_fv});
		chk("vbus valid", 8'h00, {7'h00, vb_fv});
	endtask

	initial begin
		req       = '0;
		cc1_mv    = 16'h0000;
		cc2_mv    = 16'h0000;
		vbus_mv   = 16'h0000;
		conn      = attached_sink;
		role_dfp  = 1'b1;
		alone     = 1'b0;
		cc_en     = 1'b0;
		vb_en     = 1'b0;
		cc1_dc    = 8'h00;
		cc2_dc    = 8'h00;
		vb_dc     = 8'h00;
		err_total = 0;
		cmp_count = 0;
		cycles    = 0;
		srst      = 1'b1;
		cyc(5);
		srst <= 1'b0;
		t_reset();
		t_raw();
		t_collide();
		t_vbus();
		t_line_debounce();
		t_alone();
		summarize();
	end
endmodule

`default_nettype wire
